// >>> core/acal_params.svh
// constants of the calibration engine: register offsets, reset values,
// averaging and scaling figures; included by the package and the engine
`ifndef ACAL_PARAMS_SVH
`define ACAL_PARAMS_SVH
// register offsets on the byte-wide register port
`define ACAL_A_MOFF0 8'h07
`define ACAL_A_MOFF1 8'h08
`define ACAL_A_MOFF2 8'h09
`define ACAL_A_MGAIN0 8'h0A
`define ACAL_A_MGAIN1 8'h0B
`define ACAL_A_MGAIN2 8'h0C
`define ACAL_A_AOFF0 8'h17
`define ACAL_A_AOFF1 8'h18
`define ACAL_A_AGAIN0 8'h19
`define ACAL_A_AGAIN1 8'h1A
`define ACAL_A_CMD 8'h20
`define ACAL_A_CTRL 8'h21
`define ACAL_A_STAT 8'h22
// reset values: unity gain, no offset
`define ACAL_RST_MGAIN 24'h400000
`define ACAL_RST_AGAIN 16'h4000
`define ACAL_RST_MOFF 24'h000000
`define ACAL_RST_AOFF 16'h0000
// averaging: 16 readings, divide by shifting 4
`define ACAL_NAVG_LAST 4'hF
`define ACAL_GAIN_SHIFT_M 22
`define ACAL_GAIN_SHIFT_A 14
// full-scale code scaled by the unity gain word
`define ACAL_NUM_M 56'h1FFFFFFFC00000
`define ACAL_NUM_A 56'h00001FFFFFC000
`define ACAL_DIV_LAST 6'h37
`endif

// >>> core/acal_pkg.sv
// types of the calibration engine
// assumes acal_params.svh sits beside it
package acal_pkg;
  `include "acal_params.svh"
  typedef enum logic [1:0] {ST_IDLE, ST_ACC, ST_DIV} acal_state_t;
  // command codes written to the command register
  typedef enum logic [2:0] {
    CMD_NONE, CMD_MAIN_INT_OFF, CMD_MAIN_SYS_OFF, CMD_AUX_INT_OFF,
    CMD_AUX_SYS_OFF, CMD_MAIN_SYS_GAIN, CMD_AUX_SYS_GAIN
  } acal_cmd_t;
  // correction words travelling together
  typedef struct packed {
    logic [23:0] main_gain_word;
    logic [23:0] main_offset_word;
    logic [15:0] aux_gain_word;
    logic [15:0] aux_offset_word;
  } acal_coef_t;
endpackage

// >>> core/acal_engine.sv
// calibration engine: correction words, command-started calibration
// and the correction datapath of the main and auxiliary converters.
// assumes filter results arrive as one-cycle strobes on mclk_i and the
// serial clock pins come from outside and are synchronised here.
//
// How it works
// RL1: main gain word is 24 bits in three bytes, 400000h is unity.
// RL2: main gain scales linearly, 433333h gives 1.05, 3CCCCCh gives 0.95.
// RL3: aux gain word is 16 bits in two bytes, 4000h is unity.
// RL4: aux gain above 4000h raises the aux gain in proportion.
// RL5: main internal offset: short amp inputs, average 16, store offset.
// RL6: host opens all main inputs before internal offset, restores after.
// RL7: main system offset: average 16 shorted readings into offset word.
// RL8: chop mode disables the main offset correction.
// RL9: host opens aux inputs; device shorts, averages 16, stores offset.
// RL10: aux system offset: average 16 readings into aux offset word.
// RL11: main full-scale: average 16, gain maps input to full scale.
// RL12: aux full-scale: average 16, gain maps input to full scale.
// RL13: host applies settled full-scale input, at most 106 percent.
// RL14: host calibrates offset before full scale, reference settled.
// RL15: host starts continuous conversions before a calibration.
// RL16: command starts calibration, main ready line held high.
// RL17: host keeps chip select and serial clock low during calibration.
// RL18: main completion writes words, ready low, next data corrected.
// RL19: aux gives no completion flag, host waits the tabulated time.
// RL20: main calibration time follows data rate and filter mode.
// RL21: main out is (data minus offset) times gain over 400000h, clipped.
// RL22: main offset is left-aligned to 32 bits; zero means no correction.
// RL23: aux offset is aligned to 24 bits and subtracted.
// RL24: host-written words apply from the next completed conversion.
`include "acal_params.svh"
module acal_engine import acal_pkg::*; (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o,
  // serial pins; only the serial clock is watched in the calibration interval
  input wire logic sclk_i,
  input wire logic cs_n_i,
  // filter results
  input wire logic main_conv_valid_i,
  input wire logic [31:0] main_conv_i,
  input wire logic aux_conv_valid_i,
  input wire logic [23:0] aux_conv_i,
  // corrected results and status
  output logic main_valid_o,
  output logic [31:0] main_data_o,
  output logic aux_valid_o,
  output logic [23:0] aux_data_o,
  output logic result_ready_n_o,
  output logic main_short_o,
  output logic aux_short_o,
  output logic cal_busy_o
);

  //////////////////////////////////////////////////////////////////////
  // state
  acal_coef_t coef_q, coef_d;
  acal_state_t st_q, st_d;
  acal_cmd_t kind_q, kind_d;
  logic chop_q, chop_d;
  logic [3:0] cnt_q, cnt_d;
  logic signed [35:0] sum_q, sum_d;
  logic [55:0] num_q, num_d;
  logic [32:0] rem_q, rem_d;
  logic [31:0] den_q, den_d;
  logic [5:0] dcnt_q, dcnt_d;
  logic rdy_n_q, rdy_n_d;
  logic dist_q, dist_d;
  logic [7:0] rdata_q, rdata_d;
  logic mshort_q, mshort_d, ashort_q, ashort_d, busy_q, busy_d;
  logic is_main, smp_vld, ge, den_ok, cmd_ok, sclk_rise;
  logic signed [31:0] smp, avg;
  logic signed [32:0] den;
  logic [32:0] trial;
  acal_cmd_t wcmd;

  //////////////////////////////////////////////////////////////////////
  // serial pin synchronisers; only the second stage is looked at
  // reset to the idle levels (select high, clock low) so that no false
  // clock edge is seen right after reset
  logic [1:0] pin_m_q, pin_s_q;
  logic sclk_old_q;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_m_q <= 2'h2;
      pin_s_q <= 2'h2;
      sclk_old_q <= 1'b0;
    end else begin
      pin_m_q <= {cs_n_i, sclk_i};
      pin_s_q <= pin_m_q;
      sclk_old_q <= pin_s_q[0];
    end
  end
  assign sclk_rise = pin_s_q[0] & ~sclk_old_q;

  //////////////////////////////////////////////////////////////////////
  // calibration sample and gain divider terms
  assign is_main = (kind_q == CMD_MAIN_INT_OFF) ||
                   (kind_q == CMD_MAIN_SYS_OFF) ||
                   (kind_q == CMD_MAIN_SYS_GAIN);
  assign smp_vld = is_main ? main_conv_valid_i : aux_conv_valid_i;
  assign smp = is_main ? $signed(main_conv_i)
                       : $signed({{8{aux_conv_i[23]}}, aux_conv_i});
  assign avg = sum_q[35:4]; // average of 16 by shifting
  // gain input is the reading with the present offset taken off
  always_comb begin
    if (is_main) begin
      den = {avg[31], avg} - (chop_q ? 33'sh0 :
            $signed({coef_q.main_offset_word[23], coef_q.main_offset_word,
                     8'h00}));
    end else begin
      den = {avg[31], avg} - $signed({{9{coef_q.aux_offset_word[15]}},
            coef_q.aux_offset_word, 8'h00});
    end
  end
  assign den_ok = ~den[32] && (den != 33'sh0);
  assign trial = {rem_q[31:0], num_q[55]};
  assign ge = trial >= {1'b0, den_q};
  assign wcmd = acal_cmd_t'(wdata_i[2:0]);
  assign cmd_ok = (wdata_i[2:0] != 3'h0) && (wdata_i[2:0] != 3'h7);

  //////////////////////////////////////////////////////////////////////
  // register file and calibration sequencer
  always_comb begin
    coef_d = coef_q;
    st_d = st_q;
    kind_d = kind_q;
    chop_d = chop_q;
    cnt_d = cnt_q;
    sum_d = sum_q;
    num_d = num_q;
    rem_d = rem_q;
    den_d = den_q;
    dcnt_d = dcnt_q;
    rdy_n_d = rdy_n_q;
    dist_d = dist_q;
    rdata_d = 8'h00;
    // unlatched words apply at the next conversion strobe
    if (we_i) begin // RL24
      unique case (addr_i)
        `ACAL_A_MOFF0: coef_d.main_offset_word[7:0] = wdata_i;
        `ACAL_A_MOFF1: coef_d.main_offset_word[15:8] = wdata_i;
        `ACAL_A_MOFF2: coef_d.main_offset_word[23:16] = wdata_i;
        `ACAL_A_MGAIN0: coef_d.main_gain_word[7:0] = wdata_i; // RL1
        `ACAL_A_MGAIN1: coef_d.main_gain_word[15:8] = wdata_i; // RL1
        `ACAL_A_MGAIN2: coef_d.main_gain_word[23:16] = wdata_i; // RL1
        `ACAL_A_AOFF0: coef_d.aux_offset_word[7:0] = wdata_i;
        `ACAL_A_AOFF1: coef_d.aux_offset_word[15:8] = wdata_i;
        `ACAL_A_AGAIN0: coef_d.aux_gain_word[7:0] = wdata_i; // RL3
        `ACAL_A_AGAIN1: coef_d.aux_gain_word[15:8] = wdata_i; // RL3
        `ACAL_A_CTRL: chop_d = wdata_i[0]; // RL8
        default: ;
      endcase
    end
    // read data, zero for unmapped offsets
    if (re_i) begin
      unique case (addr_i)
        `ACAL_A_MOFF0: rdata_d = coef_q.main_offset_word[7:0];
        `ACAL_A_MOFF1: rdata_d = coef_q.main_offset_word[15:8];
        `ACAL_A_MOFF2: rdata_d = coef_q.main_offset_word[23:16];
        `ACAL_A_MGAIN0: rdata_d = coef_q.main_gain_word[7:0];
        `ACAL_A_MGAIN1: rdata_d = coef_q.main_gain_word[15:8];
        `ACAL_A_MGAIN2: rdata_d = coef_q.main_gain_word[23:16];
        `ACAL_A_AOFF0: rdata_d = coef_q.aux_offset_word[7:0];
        `ACAL_A_AOFF1: rdata_d = coef_q.aux_offset_word[15:8];
        `ACAL_A_AGAIN0: rdata_d = coef_q.aux_gain_word[7:0];
        `ACAL_A_AGAIN1: rdata_d = coef_q.aux_gain_word[15:8];
        `ACAL_A_CMD: rdata_d = {5'h00, kind_q};
        `ACAL_A_CTRL: rdata_d = {7'h00, chop_q};
        `ACAL_A_STAT: rdata_d = {6'h00, dist_q, st_q != ST_IDLE};
        default: rdata_d = 8'h00;
      endcase
    end
    // sequencer; its writes come after the bus so hardware wins
    unique case (st_q)
      ST_IDLE: begin
        if (we_i && addr_i == `ACAL_A_CMD && cmd_ok) begin
          kind_d = wcmd;
          st_d = ST_ACC;
          cnt_d = 4'h0;
          sum_d = 36'sh0;
          dist_d = 1'b0;
          if ((wcmd == CMD_MAIN_INT_OFF) || (wcmd == CMD_MAIN_SYS_OFF) ||
              (wcmd == CMD_MAIN_SYS_GAIN)) begin
            rdy_n_d = 1'b1; // RL16
          end
        end
      end
      // length follows the conversion rate and filter in use
      ST_ACC: begin // RL20
        if (smp_vld) begin
          sum_d = sum_q + 36'(smp); // RL5 RL7 RL10 RL11 RL12
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == `ACAL_NAVG_LAST) begin
            st_d = ST_IDLE;
            unique case (kind_q)
              CMD_MAIN_INT_OFF, CMD_MAIN_SYS_OFF: begin
                coef_d.main_offset_word = sum_d[35:12]; // RL5 RL7 RL22
                rdy_n_d = 1'b0; // RL18
              end
              CMD_AUX_INT_OFF, CMD_AUX_SYS_OFF: begin
                coef_d.aux_offset_word = sum_d[27:12]; // RL9 RL10 RL23
              end
              default: begin
                st_d = ST_DIV;
              end
            endcase
          end
        end
      end
      // first cycle of the divide loads the operands
      ST_DIV: begin
        if (dcnt_q == 6'h00 && rem_q[32]) begin
          rem_d = 33'h0;
          den_d = den[31:0];
          num_d = is_main ? `ACAL_NUM_M : `ACAL_NUM_A;
          if (!den_ok) begin
            // non-positive reading: saturate the gain word
            st_d = ST_IDLE;
            if (is_main) begin
              coef_d.main_gain_word = 24'hFFFFFF;
              rdy_n_d = 1'b0; // RL18
            end else begin
              coef_d.aux_gain_word = 16'hFFFF;
            end
          end
        end else begin
          rem_d = {1'b0, ge ? trial[31:0] - den_q : trial[31:0]};
          num_d = {num_q[54:0], ge};
          dcnt_d = dcnt_q + 6'h01;
          if (dcnt_q == `ACAL_DIV_LAST) begin
            st_d = ST_IDLE;
            dcnt_d = 6'h00;
            if (is_main) begin
              coef_d.main_gain_word = (|num_d[55:24]) ? 24'hFFFFFF
                                      : num_d[23:0]; // RL11 RL2
              rdy_n_d = 1'b0; // RL18
            end else begin
              coef_d.aux_gain_word = (|num_d[55:16]) ? 16'hFFFF
                                     : num_d[15:0]; // RL12 RL4
            end
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // flag a serial clock edge in the quiet interval; set wins
    if (st_q != ST_IDLE && sclk_rise) begin // RL17
      dist_d = 1'b1;
    end
    // a fresh divide arms the operand load
    if (st_q == ST_ACC && st_d == ST_DIV) begin
      rem_d = 33'h100000000;
      dcnt_d = 6'h00;
    end
    mshort_d = (st_d != ST_IDLE) && (kind_d == CMD_MAIN_INT_OFF); // RL5
    ashort_d = (st_d != ST_IDLE) && (kind_d == CMD_AUX_INT_OFF); // RL9
    busy_d = st_d != ST_IDLE;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      coef_q <= '{`ACAL_RST_MGAIN, `ACAL_RST_MOFF, `ACAL_RST_AGAIN,
                  `ACAL_RST_AOFF};
      st_q <= ST_IDLE;
      kind_q <= CMD_NONE;
      chop_q <= 1'b0;
      cnt_q <= 4'h0;
      sum_q <= 36'sh0;
      num_q <= 56'h0;
      rem_q <= 33'h0;
      den_q <= 32'h0;
      dcnt_q <= 6'h00;
      rdy_n_q <= 1'b1;
      dist_q <= 1'b0;
      rdata_q <= 8'h00;
      mshort_q <= 1'b0;
      ashort_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      coef_q <= coef_d;
      st_q <= st_d;
      kind_q <= kind_d;
      chop_q <= chop_d;
      cnt_q <= cnt_d;
      sum_q <= sum_d;
      num_q <= num_d;
      rem_q <= rem_d;
      den_q <= den_d;
      dcnt_q <= dcnt_d;
      rdy_n_q <= rdy_n_d;
      dist_q <= dist_d;
      rdata_q <= rdata_d;
      mshort_q <= mshort_d;
      ashort_q <= ashort_d;
      busy_q <= busy_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // correction datapath; results are held back while their own
  // converter calibrates, since its words are still changing
  logic signed [32:0] mdiff;
  logic signed [57:0] mprod;
  logic signed [35:0] mscl;
  logic signed [24:0] adiff;
  logic signed [41:0] aprod;
  logic signed [27:0] ascl;
  logic [31:0] mdata_d, mdata_q;
  logic [23:0] adata_d, adata_q;
  logic mval_d, mval_q, aval_d, aval_q;
  always_comb begin
    mdiff = $signed({main_conv_i[31], main_conv_i}) - (chop_q ? 33'sh0 :
            $signed({coef_q.main_offset_word[23],
                     coef_q.main_offset_word, 8'h00})); // RL22 RL8
    mprod = mdiff * $signed({1'b0, coef_q.main_gain_word}); // RL21 RL2
    mscl = mprod[57:`ACAL_GAIN_SHIFT_M]; // RL21
    adiff = $signed({aux_conv_i[23], aux_conv_i}) -
            $signed({coef_q.aux_offset_word[15],
                     coef_q.aux_offset_word, 8'h00}); // RL23
    aprod = adiff * $signed({1'b0, coef_q.aux_gain_word}); // RL4
    ascl = aprod[41:`ACAL_GAIN_SHIFT_A];
    // clip to the output width
    if (mscl > 36'sh07FFFFFFF) begin // RL21
      mdata_d = 32'h7FFFFFFF;
    end else if (mscl < -36'sh080000000) begin
      mdata_d = 32'h80000000;
    end else begin
      mdata_d = mscl[31:0];
    end
    if (ascl > 28'sh07FFFFF) begin
      adata_d = 24'h7FFFFF;
    end else if (ascl < -28'sh0800000) begin
      adata_d = 24'h800000;
    end else begin
      adata_d = ascl[23:0];
    end
    mval_d = main_conv_valid_i && !(busy_q && is_main);
    aval_d = aux_conv_valid_i && !(busy_q && !is_main);
    if (!mval_d) mdata_d = mdata_q;
    if (!aval_d) adata_d = adata_q;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mdata_q <= 32'h0;
      adata_q <= 24'h0;
      mval_q <= 1'b0;
      aval_q <= 1'b0;
    end else begin
      mdata_q <= mdata_d;
      adata_q <= adata_d;
      mval_q <= mval_d;
      aval_q <= aval_d;
    end
  end

  assign rdata_o = rdata_q;
  assign main_valid_o = mval_q;
  assign main_data_o = mdata_q;
  assign aux_valid_o = aval_q;
  assign aux_data_o = adata_q;
  assign result_ready_n_o = rdy_n_q;
  assign main_short_o = mshort_q;
  assign aux_short_o = ashort_q;
  assign cal_busy_o = busy_q;

endmodule // acal_engine

// >>> sim/acal_engine_monitor.sv
// port checker for the calibration engine
// assumes it is bound to acal_engine and sees only its ports
module acal_engine_monitor import acal_pkg::*; (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [7:0] rdata_o,
  // serial pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  // filter results
  input wire logic main_conv_valid_i,
  input wire logic [31:0] main_conv_i,
  input wire logic aux_conv_valid_i,
  input wire logic [23:0] aux_conv_i,
  // corrected results and status
  input wire logic main_valid_o,
  input wire logic [31:0] main_data_o,
  input wire logic aux_valid_o,
  input wire logic [23:0] aux_data_o,
  input wire logic result_ready_n_o,
  input wire logic main_short_o,
  input wire logic aux_short_o,
  input wire logic cal_busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic go;
  ////////////////////////////////////////
  // command write seen while idle; a write while busy is dropped
  assign go = we_i && addr_i == 8'h20 && !cal_busy_o;
  busy_on_a: assert property (
    go && wdata_i inside {[8'h01:8'h06]} |=> cal_busy_o)
    else $error("calibration did not start");
  bad_code_a: assert property (
    go && wdata_i inside {8'h00, 8'h07} |=> !cal_busy_o)
    else $error("unknown code started a calibration");
  ready_hi_a: assert property (
    go && wdata_i inside {8'h01, 8'h02, 8'h05} |=> result_ready_n_o)
    else $error("ready not raised at main calibration");
  main_short_a: assert property (
    go && wdata_i == 8'h01 |=> main_short_o [*2])
    else $error("main inputs not shorted");
  aux_short_a: assert property (
    go && wdata_i == 8'h03 |=> aux_short_o)
    else $error("aux inputs not shorted");
  ready_low_a: assert property (
    $fell(main_short_o) |-> !result_ready_n_o)
    else $error("ready not lowered at completion");
  cal_quiet_a: assert property (
    main_short_o && $past(main_short_o) |-> !main_valid_o && result_ready_n_o)
    else $error("result emitted during calibration");
  main_lat_a: assert property (
    main_conv_valid_i && !cal_busy_o && !we_i |=> main_valid_o)
    else $error("main result late");
  aux_lat_a: assert property (
    aux_conv_valid_i && !cal_busy_o && !we_i |=> aux_valid_o)
    else $error("aux result late");
  cover property (go && wdata_i == 8'h05);
  cover property ($fell(cal_busy_o));
  cover property (main_valid_o && aux_short_o);
endmodule // acal_engine_monitor

bind acal_engine acal_engine_monitor i_mon (
  .mclk_i, .sys_rst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .sclk_i,
  .cs_n_i, .main_conv_valid_i, .main_conv_i, .aux_conv_valid_i, .aux_conv_i,
  .main_valid_o, .main_data_o, .aux_valid_o, .aux_data_o, .result_ready_n_o,
  .main_short_o, .aux_short_o, .cal_busy_o
);

// >>> sim/acal_host_model.sv
// host side model: conversion results and serial pin levels
// assumes the bench pulses go_i for one cycle to ask for n_i results
module acal_host_model import acal_pkg::*; (
  // clock
  input wire logic mclk_i,
  // requests from the bench
  input wire logic go_i,
  input wire logic aux_i,
  input wire logic [4:0] n_i,
  input wire logic [31:0] val_i,
  input wire logic sclk_run_i,
  // towards the engine
  output logic main_conv_valid_o,
  output logic [31:0] main_conv_o,
  output logic aux_conv_valid_o,
  output logic [23:0] aux_conv_o,
  output logic sclk_o,
  output logic cs_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int left = 0;
  int gap = 0;
  ////////////////////////////////////////
  initial begin
    main_conv_valid_o = 1'b0;
    aux_conv_valid_o = 1'b0;
    main_conv_o = 32'h0;
    aux_conv_o = 24'h0;
    sclk_o = 1'b0;
  end
  // conversions keep running through a calibration, three idle cycles
  // apart; idle data is inverted so a stale sample never looks valid
  always @(posedge mclk_i) begin
    main_conv_valid_o <= 1'b0;
    aux_conv_valid_o <= 1'b0;
    main_conv_o <= ~val_i;
    aux_conv_o <= ~val_i[23:0];
    if (go_i) begin
      left <= n_i;
      gap <= 0;
    end else if (left > 0 && gap == 0) begin
      main_conv_valid_o <= !aux_i;
      aux_conv_valid_o <= aux_i;
      main_conv_o <= val_i;
      aux_conv_o <= val_i[23:0];
      left <= left - 1;
      gap <= 3;
    end else if (gap > 0) begin
      gap <= gap - 1;
    end
  end
  // serial clock rests low; it only runs when the bench breaks that
  always #80 sclk_o = sclk_run_i ? ~sclk_o : 1'b0;
  assign cs_n_o = 1'b0;
endmodule // acal_host_model

// >>> sim/acal_engine_tb.sv
// self-checking bench for the calibration engine
// assumes the monitor binds itself and the host model drives the pins
module acal_engine_tb import acal_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic go = 1'b0;
  logic aux = 1'b0;
  logic run = 1'b0;
  logic [4:0] n = 5'h00;
  logic [31:0] val = 32'h0;
  logic [7:0] rdata;
  logic mcv, acv, sclk, cs_n, mv, av, rdy_n, busy;
  logic [31:0] mc, md;
  logic [23:0] ac, ad;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  // rows: address, byte written, byte read back
  logic [23:0] rows [6] = '{24'h0A3333, 24'h0B3333, 24'h0C4343,
    24'h190000, 24'h1A5050, 24'h30AA00};
  ////////////////////////////////////////
  always #10 mclk = ~mclk;
  acal_engine i_dut (.mclk_i(mclk), .sys_rst_i(rst), .addr_i(addr),
    .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata), .sclk_i(sclk),
    .cs_n_i(cs_n), .main_conv_valid_i(mcv), .main_conv_i(mc),
    .aux_conv_valid_i(acv), .aux_conv_i(ac), .main_valid_o(mv),
    .main_data_o(md), .aux_valid_o(av), .aux_data_o(ad),
    .result_ready_n_o(rdy_n), .main_short_o(), .aux_short_o(),
    .cal_busy_o(busy));
  acal_host_model i_host (.mclk_i(mclk), .go_i(go), .aux_i(aux), .n_i(n),
    .val_i(val), .sclk_run_i(run), .main_conv_valid_o(mcv),
    .main_conv_o(mc), .aux_conv_valid_o(acv), .aux_conv_o(ac),
    .sclk_o(sclk), .cs_n_o(cs_n));
  // the run needs about 600 cycles; a hang is cut off well after
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge mclk);
    we <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    re <= 1'b1;
    @(posedge mclk);
    re <= 1'b0;
    @(posedge mclk);
    chk(rdata, e);
  endtask
  // one conversion through the model, corrected result compared
  task automatic conv(input logic ax, input logic [31:0] x,
    input logic [31:0] e);
    go <= 1'b1;
    aux <= ax;
    n <= 5'h01;
    val <= x;
    @(posedge mclk);
    go <= 1'b0;
    for (int i = 0; i < 40 && !(ax ? av : mv); i++) @(posedge mclk);
    chk(ax ? {8'h00, ad} : md, e);
  endtask
  // calibration: command, sixteen results, bounded wait for the end
  task automatic cal(input logic [7:0] c, input logic ax,
    input logic [31:0] v);
    wr(8'h20, c);
    @(posedge mclk);
    chk(busy, 1'b1);
    go <= 1'b1;
    aux <= ax;
    n <= 5'h10;
    val <= v;
    @(posedge mclk);
    go <= 1'b0;
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge mclk);
    chk(busy, 1'b0);
    if (!ax) chk(rdy_n, 1'b0);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(8'h0C, 8'h40);
    rd(8'h0A, 8'h00);
    rd(8'h1A, 8'h40);
    $display("test reset done");
    foreach (rows[k]) begin
      wr(rows[k][23:16], rows[k][15:8]);
      rd(rows[k][23:16], rows[k][7:0]);
    end
    conv(1'b0, 32'h0040_0000, 32'h0043_3333);
    conv(1'b0, 32'h7FFF_FFFF, 32'h7FFF_FFFF);
    conv(1'b1, 32'h0000_4000, 32'h0000_5000);
    $display("test registers done");
    wr(8'h20, 8'h07);
    @(posedge mclk);
    chk(busy, 1'b0);
    cal(8'h01, 1'b0, 32'h0000_1200);
    rd(8'h07, 8'h12);
    run <= 1'b1;
    cal(8'h02, 1'b0, 32'h0000_2400);
    run <= 1'b0;
    rd(8'h07, 8'h24);
    rd(8'h22, 8'h02);
    cal(8'h03, 1'b1, 32'h0000_0340);
    rd(8'h17, 8'h03);
    cal(8'h04, 1'b1, 32'h0000_0540);
    rd(8'h17, 8'h05);
    conv(1'b0, 32'h0040_2400, 32'h0043_3333);
    conv(1'b1, 32'h0000_4500, 32'h0000_5000);
    wr(8'h21, 8'h01);
    conv(1'b0, 32'h0040_0000, 32'h0043_3333);
    wr(8'h21, 8'h00);
    // let an edge pass so the write strobe is not raised again at once
    @(posedge mclk);
    cal(8'h05, 1'b0, 32'h4000_2400);
    rd(8'h0C, 8'h7F);
    rd(8'h0A, 8'hFF);
    conv(1'b0, 32'h4000_2400, 32'h7FFF_FF00);
    cal(8'h06, 1'b1, 32'h0040_0500);
    rd(8'h1A, 8'h7F);
    rd(8'h19, 8'hFF);
    $display("test calibration done");
    end_sim();
  end
endmodule // acal_engine_tb
